//--- design/io_expander_params.svh
// Constants for the I2C eight-bit port expander and its bus master
`ifndef IO_EXPANDER_PARAMS_SVH
`define IO_EXPANDER_PARAMS_SVH
`define ADDR_FIXED_BITS 4'h7
`define REG_PIN_LEVEL 2'h0
`define REG_DRIVE_LATCH 2'h1
`define REG_INVERT_MASK 2'h2
`define REG_DIRECTION 2'h3
`define RST_DRIVE_LATCH 8'hff
`define RST_INVERT_MASK 8'h00
`define RST_DIRECTION 8'hff
`define RST_POINTER 8'h00
`define SCL_HALF_DIV 8'h1f
`endif

//--- design/io_expander_pkg.sv
// Types shared by both ends of the expander link
package io_expander_pkg;
   typedef enum logic [7:0] {
      S_IDLE = 8'h01,
      S_ADDR = 8'h02,
      S_ADDR_ACK = 8'h04,
      S_RX = 8'h08,
      S_RX_ACK = 8'h10,
      S_TX = 8'h20,
      S_TX_ACK = 8'h40,
      S_IGNORE = 8'h80
   } slave_state_e;
   typedef enum logic [6:0] {
      M_IDLE = 7'h01,
      M_START = 7'h02,
      M_BIT = 7'h04,
      M_ACK = 7'h08,
      M_STOP = 7'h10,
      M_RESTART = 7'h20,
      M_DONE = 7'h40
   } master_state_e;
endpackage

//--- design/i2c_link_if.sv
// Two-wire link between the expander and its master
`timescale 1ns/1ns
interface i2c_link_if;
   logic scl_out;
   logic scl_oe_n;
   logic sda_m_out;
   logic sda_m_oe_n;
   logic sda_s_out;
   logic sda_s_oe_n;
   // Wired-and with pull-ups on both lines
   wire scl = scl_oe_n ? 1'b1 : scl_out;
   wire sda = (sda_m_oe_n ? 1'b1 : sda_m_out) &
      (sda_s_oe_n ? 1'b1 : sda_s_out);
   modport expander (input scl, input sda, output sda_s_out,
      output sda_s_oe_n);
   modport master (input scl, input sda, output scl_out, output scl_oe_n,
      output sda_m_out, output sda_m_oe_n);
endinterface

//--- design/i2c_io_expander.sv
// Expander end: I2C slave, four port registers and change flag
`timescale 1ns/1ns
`include "io_expander_params.svh"
// How it works
// (R01) Answers address 0111 plus three select pins
// (R02) Eighth address bit one means read
// (R03) First written byte after address is command
// (R04) Command low bits pick one register
// (R05) Reads keep using last selected register
// (R06) Pointer register written and read back
// (R07) Input register shows all eight pin levels
// (R08) Writes to input register acknowledged, dropped
// (R09) Input register has no reset value
// (R10) Output register reads latch, not pins
// (R11) Output bits drive only output pins
// (R12) Invert bit flips reported input level
// (R13) Direction one input, zero output
// (R14) Write: address, command, many data bytes
// (R15) Read: command write, restart, read address
// (R16) Master ends read with not-acknowledge
// (R17) Read data captured at acknowledge edge
// (R18) Stop at any byte returns idle
// (R19) Acknowledge address and every received byte
// (R20) Change flag on input edge, clears on read
// (R21) Output pins never raise change flag
// (R22) Upper command bits ignored, foreign address not acked
// (R23) Pointer never advances on repeated bytes
module i2c_io_expander
   import io_expander_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   i2c_link_if.expander link,
   input wire logic addr_sel_msb,
   input wire logic addr_sel_mid,
   input wire logic addr_sel_lsb,
   input wire logic [7:0] port_in,
   output logic [7:0] port_out,
   output logic [7:0] port_oe_n,
   output logic change_int_n,
   output logic [7:0] register_pointer
);
   slave_state_e state;
   logic [7:0] drive_level_latch;
   logic [7:0] input_invert_mask;
   logic [7:0] direction_select;
   logic [7:0] int_ref;
   logic [7:0] shifter;
   logic [7:0] tx_byte;
   logic [3:0] bit_cnt;
   logic scl_q;
   logic sda_q;
   logic sda_drive;
   logic is_read;
   logic got_cmd;
   logic [7:0] pin_level_sample;
   logic [7:0] selected_value;
   logic [6:0] own_addr;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic addr_match;

   // Bus edge and condition detection; link inputs are synchronous
   assign scl_rise = link.scl & ~scl_q;
   assign scl_fall = ~link.scl & scl_q;
   assign start_seen = link.scl & scl_q & sda_q & ~link.sda;
   assign stop_seen = link.scl & scl_q & ~sda_q & link.sda;
   assign own_addr = {`ADDR_FIXED_BITS, addr_sel_msb, addr_sel_mid,
      addr_sel_lsb}; // R01
   assign addr_match = shifter[7:1] == own_addr; // R01 R22

   // Input register follows pins, no storage so no reset value
   assign pin_level_sample = port_in ^ (input_invert_mask &
      direction_select); // R07 R09 R12
   // Only low two pointer bits select
   assign selected_value =
      (register_pointer[1:0] == `REG_PIN_LEVEL) ? pin_level_sample :
      (register_pointer[1:0] == `REG_DRIVE_LATCH) ? drive_level_latch :
      (register_pointer[1:0] == `REG_INVERT_MASK) ? input_invert_mask :
      direction_select; // R04 R10 R22

   // Pins: direction one releases the driver
   assign port_out = drive_level_latch; // R11
   assign port_oe_n = direction_select; // R13 R11
   // Flag when any input pin differs from its raw level at the last input register read
   assign change_int_n = ~|((port_in ^ int_ref) & direction_select); // R20 R21
   assign link.sda_s_out = 1'b0;
   assign link.sda_s_oe_n = ~sda_drive;

   // Bus sampling for edge detection
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= link.scl;
         sda_q <= link.sda;
      end
   end

   // Slave protocol engine and register writes
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= S_IDLE;
         bit_cnt <= 4'h0;
         shifter <= 8'h00;
         tx_byte <= 8'h00;
         sda_drive <= 1'b0;
         is_read <= 1'b0;
         got_cmd <= 1'b0;
         register_pointer <= `RST_POINTER;
         drive_level_latch <= `RST_DRIVE_LATCH;
         input_invert_mask <= `RST_INVERT_MASK;
         direction_select <= `RST_DIRECTION;
         int_ref <= 8'hff;
      end
      else if (stop_seen)
      begin
         state <= S_IDLE; // R18
         sda_drive <= 1'b0;
      end
      else if (start_seen)
      begin
         state <= S_ADDR; // Repeated start keeps the pointer R05
         bit_cnt <= 4'h0;
         sda_drive <= 1'b0;
      end
      else
      begin
         case (state)
            S_IDLE, S_IGNORE:
            begin
               sda_drive <= 1'b0;
            end
            S_ADDR, S_RX:
            begin
               if (scl_rise)
               begin
                  shifter <= {shifter[6:0], link.sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               else if (scl_fall && bit_cnt == 4'h8)
               begin
                  bit_cnt <= 4'h0;
                  if (state == S_ADDR)
                  begin
                     if (addr_match)
                     begin
                        sda_drive <= 1'b1; // R19
                        is_read <= shifter[0]; // R02
                        got_cmd <= 1'b0; // R03
                        state <= S_ADDR_ACK;
                     end
                     else
                     begin
                        state <= S_IGNORE; // R22
                     end
                  end
                  else
                  begin
                     sda_drive <= 1'b1; // R19 R08
                     state <= S_RX_ACK;
                     if (!got_cmd)
                     begin
                        register_pointer <= shifter; // R03 R06
                        got_cmd <= 1'b1;
                     end
                     else if (register_pointer[1:0] == `REG_DRIVE_LATCH)
                        drive_level_latch <= shifter; // R14 R23
                     else if (register_pointer[1:0] == `REG_INVERT_MASK)
                        input_invert_mask <= shifter; // R14 R23
                     else if (register_pointer[1:0] == `REG_DIRECTION)
                        direction_select <= shifter; // R14 R23
                  end
               end
            end
            S_ADDR_ACK, S_RX_ACK:
            begin
               // Read data latched at the acknowledge clock rise
               if (scl_rise && state == S_ADDR_ACK && is_read)
               begin
                  tx_byte <= selected_value; // R17 R15
                  if (register_pointer[1:0] == `REG_PIN_LEVEL)
                     int_ref <= port_in; // R20
               end
               if (scl_fall)
               begin
                  if (is_read && state == S_ADDR_ACK)
                  begin
                     state <= S_TX;
                     sda_drive <= ~tx_byte[7];
                     tx_byte <= {tx_byte[6:0], 1'b1};
                     bit_cnt <= 4'h1;
                  end
                  else
                  begin
                     state <= S_RX;
                     sda_drive <= 1'b0;
                  end
               end
            end
            S_TX:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt == 4'h8)
                  begin
                     sda_drive <= 1'b0; // Release for master ack
                     state <= S_TX_ACK;
                  end
                  else
                  begin
                     sda_drive <= ~tx_byte[7];
                     tx_byte <= {tx_byte[6:0], 1'b1};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            S_TX_ACK:
            begin
               if (scl_rise)
               begin
                  if (link.sda)
                     state <= S_IGNORE; // R16 released on nack
                  else
                  begin
                     tx_byte <= selected_value; // R17 R05
                     if (register_pointer[1:0] == `REG_PIN_LEVEL)
                        int_ref <= port_in; // R20
                  end
               end
               else if (scl_fall)
               begin
                  state <= S_TX;
                  sda_drive <= ~tx_byte[7];
                  tx_byte <= {tx_byte[6:0], 1'b1};
                  bit_cnt <= 4'h1;
               end
            end
            default:
            begin
               state <= S_IDLE;
            end
         endcase
      end
   end
endmodule

//--- design/i2c_expander_master.sv
// Master end: drives byte writes and register reads over the link
`timescale 1ns/1ns
`include "io_expander_params.svh"
module i2c_expander_master
   import io_expander_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   i2c_link_if.master link,
   input wire logic req_valid,
   input wire logic req_read,
   input wire logic [6:0] req_addr,
   input wire logic [7:0] req_cmd,
   input wire logic [7:0] req_data,
   output logic req_ready,
   output logic done,
   output logic nacked,
   output logic [7:0] rd_data
);
   master_state_e state;
   logic [7:0] half_cnt;
   logic tick;
   logic phase;
   logic [2:0] byte_idx;
   logic [3:0] bit_cnt;
   logic [8:0] shifter;
   logic rd_op;
   logic [6:0] addr_q;
   logic [7:0] cmd_q;
   logic [7:0] data_q;
   logic scl_low;
   logic sda_low;

   // Half-bit enable from the system clock
   assign tick = half_cnt == `SCL_HALF_DIV;
   assign req_ready = state == M_IDLE;
   assign link.scl_out = 1'b0;
   assign link.scl_oe_n = ~scl_low;
   assign link.sda_m_out = 1'b0;
   assign link.sda_m_oe_n = ~sda_low;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         half_cnt <= 8'h00;
      else
         half_cnt <= tick ? 8'h00 : half_cnt + 8'h01;
   end

   // Bytes: 0 write address, 1 command, 2 data or read address, 3 read
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= M_IDLE;
         phase <= 1'b0;
         byte_idx <= 3'h0;
         bit_cnt <= 4'h0;
         shifter <= 9'h1ff;
         rd_op <= 1'b0;
         addr_q <= 7'h00;
         cmd_q <= 8'h00;
         data_q <= 8'h00;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         done <= 1'b0;
         nacked <= 1'b0;
         rd_data <= 8'h00;
      end
      else
      begin
         done <= 1'b0;
         case (state)
            M_IDLE:
            begin
               if (req_valid)
               begin
                  rd_op <= req_read;
                  addr_q <= req_addr;
                  cmd_q <= req_cmd;
                  data_q <= req_data;
                  nacked <= 1'b0;
                  byte_idx <= 3'h0;
                  phase <= 1'b0;
                  state <= M_START;
               end
            end
            M_START:
            begin
               if (tick)
               begin
                  if (!phase)
                     sda_low <= 1'b1; // Start: sda falls, scl high
                  else
                  begin
                     scl_low <= 1'b1;
                     sda_low <= ~addr_q[6]; // R14 R15 first address bit
                     shifter <= {addr_q, byte_idx[1], 1'b1};
                     bit_cnt <= 4'h0;
                     state <= M_BIT;
                  end
                  phase <= ~phase;
               end
            end
            M_BIT:
            begin
               if (tick)
               begin
                  if (!phase)
                     scl_low <= 1'b0;
                  else
                  begin
                     // Next bit moves as scl falls, so sda is already
                     // released when the far end answers in the ack slot
                     scl_low <= 1'b1;
                     shifter <= {shifter[7:0], link.sda};
                     bit_cnt <= bit_cnt + 4'h1;
                     if (bit_cnt == 4'h8)
                        state <= M_ACK;
                     else
                        sda_low <= ~shifter[7];
                  end
                  phase <= ~phase;
               end
            end
            M_ACK:
            begin
               // Ack bit sampled into shifter[0]; read data in [8:1]
               phase <= 1'b0;
               if (byte_idx == 3'h3)
               begin
                  rd_data <= shifter[8:1];
                  state <= M_STOP;
               end
               else if (shifter[0])
               begin
                  nacked <= 1'b1;
                  state <= M_STOP;
               end
               else if (byte_idx == 3'h1 && rd_op)
               begin
                  byte_idx <= 3'h2;
                  state <= M_RESTART; // R15
               end
               else if (byte_idx == 3'h2)
               begin
                  if (rd_op)
                  begin
                     // Read byte; our ack slot sends nack (all ones)
                     byte_idx <= 3'h3;
                     sda_low <= 1'b0; // R16 byte and ack slot released
                     shifter <= 9'h1ff;
                     bit_cnt <= 4'h0;
                     state <= M_BIT;
                  end
                  else
                     state <= M_STOP;
               end
               else
               begin
                  byte_idx <= byte_idx + 3'h1;
                  sda_low <= (byte_idx == 3'h0) ? ~cmd_q[7] : ~data_q[7];
                  // R03 R14 (line above)
                  shifter <= (byte_idx == 3'h0) ? {cmd_q, 1'b1} :
                     {data_q, 1'b1};
                  bit_cnt <= 4'h0;
                  state <= M_BIT;
               end
            end
            M_RESTART:
            begin
               if (tick)
               begin
                  sda_low <= 1'b0;
                  if (phase)
                  begin
                     scl_low <= 1'b0;
                     phase <= 1'b0;
                     state <= M_START;
                  end
                  else
                     phase <= 1'b1;
               end
            end
            M_STOP:
            begin
               if (tick)
               begin
                  if (!phase)
                  begin
                     sda_low <= 1'b1;
                     phase <= 1'b1;
                  end
                  else if (scl_low)
                     scl_low <= 1'b0;
                  else
                  begin
                     sda_low <= 1'b0; // Stop: sda rises, scl high R18
                     state <= M_DONE;
                  end
               end
            end
            M_DONE:
            begin
               done <= 1'b1;
               state <= M_IDLE;
            end
            default:
            begin
               state <= M_IDLE;
            end
         endcase
      end
   end
endmodule

//--- verification/i2c_link_monitor.sv
// Checker watching the two-wire link between expander and master
`timescale 1ns/1ns
module i2c_link_monitor (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic sda_m_out,
   input wire logic sda_m_oe_n,
   input wire logic sda_s_out,
   input wire logic sda_s_oe_n
);
   default clocking link_clk @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   // Open-drain drivers may only ever pull low
   slave_pull_low_a: assert property (
      !sda_s_oe_n |-> !sda_s_out) else $error("expander drives sda high");
   master_pull_low_a: assert property (
      !scl_oe_n |-> !scl_out) else $error("master drives scl high");
   // Both ends pulling at once means a turnaround was missed
   no_clash_a: assert property (
      sda_s_oe_n || sda_m_oe_n) else $error("both ends drive sda");
   // Expander must never move sda while the clock is high
   slave_stable_a: assert property (
      (scl && $past(scl)) |-> $stable(sda_s_oe_n))
      else $error("expander moved sda with scl high");
   drive_after_fall_a: assert property (
      $fell(sda_s_oe_n) |-> !scl && !$past(scl))
      else $error("expander pulled sda outside scl low");
   slave_drive_max_a: assert property (
      $fell(sda_s_oe_n) |-> ##[1:700] sda_s_oe_n)
      else $error("expander held sda too long");
   // Clock phases last at least a quarter of the half-bit divider
   scl_low_min_a: assert property (
      $fell(scl) |-> !scl [*8]) else $error("scl low phase too short");
   scl_high_min_a: assert property (
      $rose(scl) |-> scl [*8]) else $error("scl high phase too short");
   scl_low_max_a: assert property (
      $fell(scl) |-> ##[1:200] scl) else $error("scl stuck low");
endmodule

//--- verification/i2c_io_expander_bench.sv
// Bench joining expander and master over the link
`timescale 1ns/1ns
module i2c_io_expander_bench;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [2:0] sel = 3'h0;
   logic [7:0] port_in = 8'h00;
   logic req_valid = 1'b0;
   logic req_read = 1'b0;
   logic [6:0] req_addr = 7'h38;
   logic [7:0] req_cmd = 8'h00;
   logic [7:0] req_data = 8'h00;
   logic req_ready, done, nacked, change_int_n;
   logic [7:0] rd_data, port_out, port_oe_n, register_pointer;
   int n_fail = 0;
   int checked = 0;
   i2c_link_if link ();
   i2c_io_expander i2c_io_expander_inst (.sys_clk(sys_clk),
      .reset_n(reset_n), .link(link.expander), .addr_sel_msb(sel[2]),
      .addr_sel_mid(sel[1]), .addr_sel_lsb(sel[0]), .port_in(port_in),
      .port_out(port_out), .port_oe_n(port_oe_n),
      .change_int_n(change_int_n), .register_pointer(register_pointer));
   i2c_expander_master i2c_expander_master_inst (.sys_clk(sys_clk),
      .reset_n(reset_n), .link(link.master), .req_valid(req_valid),
      .req_read(req_read), .req_addr(req_addr), .req_cmd(req_cmd),
      .req_data(req_data), .req_ready(req_ready), .done(done),
      .nacked(nacked), .rd_data(rd_data));
   i2c_link_monitor i2c_link_monitor_inst (.sys_clk(sys_clk),
      .reset_n(reset_n), .scl(link.scl), .sda(link.sda),
      .scl_out(link.scl_out), .scl_oe_n(link.scl_oe_n),
      .sda_m_out(link.sda_m_out), .sda_m_oe_n(link.sda_m_oe_n),
      .sda_s_out(link.sda_s_out), .sda_s_oe_n(link.sda_s_oe_n));

   // Free-running 25 MHz clock
   always #20 sys_clk = ~sys_clk;

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One whole transaction; request held until the edge that takes it
   task automatic xfer(input logic rd, input logic [6:0] a,
      input logic [7:0] c, input logic [7:0] d);
      int i;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_read <= rd;
      req_addr <= a;
      req_cmd <= c;
      req_data <= d;
      for (i = 0; i < 100; i++)
      begin
         @(posedge sys_clk);
         if (req_ready === 1'b1)
            break;
      end
      if (i == 100)
      begin
         n_fail++;
         close_out();
      end
      req_valid <= 1'b0;
      // Read transfers run near 2600 cycles, so 6000 is a safe bound
      for (i = 0; i < 6000; i++)
      begin
         @(posedge sys_clk);
         if (done === 1'b1)
            break;
      end
      if (i == 6000)
      begin
         n_fail++;
         close_out();
      end
   endtask

   // Settle a combinational output after a pin change
   task automatic pins(input logic [7:0] v);
      @(posedge sys_clk);
      port_in <= v;
      @(posedge sys_clk);
      @(posedge sys_clk);
   endtask

   task automatic t_reset();
      int c;
      check("pointer", 8'h00, register_pointer);
      check("drive", 8'hff, port_out);
      check("direction", 8'hff, port_oe_n);
      for (c = 1; c < 4; c++)
      begin
         xfer(1'b1, 7'h38, c[7:0], 8'h00);
         check("reset read", (c == 2) ? 8'h00 : 8'hff, rd_data);
      end
   endtask

   // Every select value answers; its neighbour address is refused
   task automatic t_address();
      int s;
      for (s = 0; s < 8; s++)
      begin
         @(posedge sys_clk);
         sel <= s[2:0];
         xfer(1'b0, {4'h7, s[2:0]}, 8'h01, {s[2:0], 5'h15});
         check("addr ack", 8'h00, {7'h00, nacked});
         check("drive", {s[2:0], 5'h15}, port_out);
         xfer(1'b0, {4'h7, s[2:0] ^ 3'h1}, 8'h01, 8'h00);
         check("foreign nack", 8'h01, {7'h00, nacked});
         check("drive kept", {s[2:0], 5'h15}, port_out);
      end
      @(posedge sys_clk);
      sel <= 3'h0;
   endtask

   task automatic t_ports();
      pins(8'hc3);
      xfer(1'b0, 7'h38, 8'h03, 8'h0f);
      xfer(1'b0, 7'h38, 8'h01, 8'h3c);
      check("direction", 8'h0f, port_oe_n);
      check("drive", 8'h3c, port_out);
      xfer(1'b0, 7'h38, 8'h00, 8'h00);
      check("input write ack", 8'h00, {7'h00, nacked});
      xfer(1'b1, 7'h38, 8'h01, 8'h00);
      check("drive read", 8'h3c, rd_data);
      xfer(1'b1, 7'h38, 8'h03, 8'h00);
      check("direction read", 8'h0f, rd_data);
   endtask

   // Upper command bits are ignored; inversion on input pins only
   task automatic t_invert();
      pins(8'h5a);
      xfer(1'b0, 7'h38, 8'hfe, 8'h33);
      check("pointer", 8'hfe, register_pointer);
      xfer(1'b1, 7'h38, 8'h02, 8'h00);
      check("invert read", 8'h33, rd_data);
      xfer(1'b1, 7'h38, 8'h00, 8'h00);
      check("input read", 8'h5a ^ (8'h33 & 8'h0f), rd_data);
   endtask

   // Change flag follows input pins against the last input read
   task automatic t_change();
      pins(8'h5a);
      check("flag idle", 8'h01, {7'h00, change_int_n});
      pins(8'h5b);
      check("flag set", 8'h00, {7'h00, change_int_n});
      pins(8'h5a);
      check("flag back", 8'h01, {7'h00, change_int_n});
      pins(8'h4a);
      check("flag output pin", 8'h01, {7'h00, change_int_n});
      pins(8'h4b);
      check("flag again", 8'h00, {7'h00, change_int_n});
      xfer(1'b1, 7'h38, 8'h00, 8'h00);
      check("input read", 8'h4b ^ 8'h03, rd_data);
      pins(8'h4b);
      check("flag cleared", 8'h01, {7'h00, change_int_n});
   endtask

   initial
   begin
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset();
      t_address();
      t_ports();
      t_invert();
      t_change();
      close_out();
   end
endmodule
